// ===== sps_regs.svh
// Register offsets, field codes, reset values and timing constants of the sleep power control
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
// Byte addresses of the register words
`define SPS_ADDR_CTRL 8'h00
`define SPS_ADDR_SLEEP 8'h04
`define SPS_ADDR_STAT 8'h08
`define SPS_ADDR_CLR 8'h0c
`define SPS_ADDR_IEN 8'h10
// Pin source selector codes
`define SPS_SRC_STATIC 3'h7
`define SPS_SRC_SLEEP 3'h6
// Reset values
`define SPS_CTRL_RST 6'h07
`define SPS_SLEEP_RST 8'h00
// Sleep timeout period and clock period, in ns
`define SPS_TICK_NS 7800000
`define SPS_CLK_NS 5
`define SPS_TICK_W 21
// AXI responses
`define SPS_RESP_OKAY 2'h0
`define SPS_RESP_SLVERR 2'h2
`endif

// ===== sps_pkg.sv
// Types shared by the sleep power control block
`include "sps_regs.svh"
package sps_pkg;
  // Power control states
  typedef enum logic [1:0] {SPS_RUN, SPS_SWAIT, SPS_SLEEP} sps_state_t;
  // Control word, bit 0 upward: source, static bit, switch enable, oscillator halt
  typedef struct packed {
    logic       stop;
    logic       low_resistance_switch_enable;
    logic       static_output_bit;
    logic [2:0] src;
  } sps_ctrl_t;
  // Sleep word: request, reset enable, two reserved, occurred flag, timeout
  typedef struct packed {
    logic       sleep_request;
    logic       sleep_reset_enable;
    logic [1:0] rsvd;
    logic       sleep_occurred_flag;
    logic [2:0] sleep_timeout_field;
  } sps_sleep_t;
  // Event bits shared by status, clear and enable words
  typedef struct packed {
    logic wake;
    logic timer;
    logic alarm;
  } sps_evt_t;
  // Registered state of the block, apart from the input synchronisers
  typedef struct packed {
    sps_state_t             fsm;
    sps_ctrl_t              ctrl;
    sps_sleep_t             sleep;
    sps_evt_t               stat;
    sps_evt_t               ien;
    logic [2:0]             wait_cnt;
    logic [`SPS_TICK_W-1:0] tick_cnt;
    logic                   tick;
    logic                   aw_ok;
    logic [7:0]             awaddr;
    logic                   w_ok;
    logic [7:0]             wdata;
    logic                   wlane;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic                   pin_o;
    logic                   pin_oe;
    logic                   rst_n;
    logic                   irq;
  } sps_st_t;
endpackage

// ===== sps_power_ctrl.sv
// Sleep power control: power switch pin, host reset and wake interrupt behind AXI4-Lite
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_power_ctrl
  import sps_pkg::*;
#(
  parameter int TICK_CYCLES = `SPS_TICK_NS / `SPS_CLK_NS
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        alarm_evt,
  input  wire logic        timer_evt,
  input  wire logic        power_switch_pin_i,
  output logic             power_switch_pin_o,
  output logic             power_switch_pin_oe,
  output logic             host_reset_out_n,
  output logic             irq
);

  // Last count of the free running timeout divider
  localparam logic [`SPS_TICK_W-1:0] TICK_LAST = `SPS_TICK_W'(TICK_CYCLES - 1);

  sps_st_t    st;          // Registered state
  sps_st_t    next_st;     // Next state
  logic [2:0] sync1;       // First synchroniser stage
  logic [2:0] sync2;       // Second synchroniser stage
  logic [2:0] sync3;       // Previous value for edge detection
  sps_evt_t   set_evt;     // Hardware events this cycle
  sps_evt_t   clr_evt;     // Software clears this cycle
  sps_sleep_t wr_sleep;    // Write data seen as sleep word
  logic       wake_hit;    // Enabled wake trigger
  logic       pending;     // Enabled status bit already set
  logic       req_ok;      // Sleep request may be accepted
  logic       wr_go;       // Register write performed this cycle
  logic       sleep_cfg;   // Pin configured as power switch

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Events and pin level come from outside the clock domain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end
    else
    begin
      sync1 <= {power_switch_pin_i, timer_evt, alarm_evt};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ****************************************************************
  // Event decode
  // ****************************************************************
  // Rising edges only, so a held level counts once
  assign set_evt.alarm = sync2[0] & ~sync3[0];
  assign set_evt.timer = sync2[1] & ~sync3[1];
  assign set_evt.wake  = (st.fsm == SPS_SLEEP) & wake_hit;
  assign wake_hit      = (set_evt.alarm & st.ien.alarm) | (set_evt.timer & st.ien.timer);
  assign pending       = |(st.stat & st.ien);
  assign wr_go         = st.aw_ok & st.w_ok & ~st.bvalid;
  assign wr_sleep      = sps_sleep_t'(st.wdata);
  assign clr_evt       = (wr_go && st.wlane && st.awaddr == `SPS_ADDR_CLR) ?
                         sps_evt_t'(st.wdata[2:0]) : sps_evt_t'(3'h0);
  assign req_ok        = ~st.ctrl.stop & (st.ien.alarm | st.ien.timer) & ~pending;
  assign sleep_cfg     = (st.ctrl.src == `SPS_SRC_SLEEP) &
                         st.ctrl.low_resistance_switch_enable;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_st = st;
    // Divider gives a one-cycle enable per timeout period
    next_st.tick     = (st.tick_cnt == TICK_LAST);
    next_st.tick_cnt = next_st.tick ? '0 : st.tick_cnt + 1'b1;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_ok  = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_ok  = 1'b1;
      next_st.wdata = s_axi_wdata[7:0];
      next_st.wlane = s_axi_wstrb[0];
    end

    // Write once both halves are held; all fields sit in byte lane 0
    if (wr_go)
    begin
      next_st.aw_ok  = 1'b0;
      next_st.w_ok   = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `SPS_RESP_OKAY;
      case (st.awaddr)
        `SPS_ADDR_CTRL:
        begin
          // only 111 and 110 are glitch free while switching
          if (st.wlane)
            next_st.ctrl = sps_ctrl_t'(st.wdata[$bits(sps_ctrl_t)-1:0]);
        end
        `SPS_ADDR_SLEEP:
        begin
          if (st.wlane)
          begin
            next_st.sleep.sleep_reset_enable  = wr_sleep.sleep_reset_enable;
            next_st.sleep.sleep_timeout_field = wr_sleep.sleep_timeout_field;
            // Writing zero clears the occurred flag
            if (!wr_sleep.sleep_occurred_flag)
              next_st.sleep.sleep_occurred_flag = 1'b0;
            if (!wr_sleep.sleep_request)
              next_st.sleep.sleep_request = 1'b0;
            else if (req_ok)
              next_st.sleep.sleep_request = 1'b1;
          end
        end
        `SPS_ADDR_IEN:
        begin
          if (st.wlane)
            next_st.ien = sps_evt_t'(st.wdata[2:0]);
        end
        `SPS_ADDR_STAT, `SPS_ADDR_CLR:
        begin
          // Status is read only; clears handled below
        end
        default:
        begin
          next_st.bresp = `SPS_RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    next_st.awready = ~next_st.aw_ok & ~next_st.bvalid;
    next_st.wready  = ~next_st.w_ok & ~next_st.bvalid;

    // events only set status; set wins over a clear
    next_st.stat = (st.stat & ~clr_evt) | set_evt;

    // Sleep sequencing overrides software writes of the same cycle
    case (st.fsm)
      SPS_RUN:
      begin
        if (st.sleep.sleep_request)
        begin
          next_st.fsm      = SPS_SWAIT;
          next_st.wait_cnt = st.sleep.sleep_timeout_field;
        end
      end
      SPS_SWAIT:
      begin
        if (wake_hit || !st.sleep.sleep_request)
        begin
          next_st.fsm                 = SPS_RUN;
          next_st.sleep.sleep_request = 1'b0;
        end
        else if (st.wait_cnt == 3'h0)
        begin
          next_st.fsm                       = SPS_SLEEP;
          next_st.sleep.sleep_occurred_flag = 1'b1;
        end
        else if (st.tick)
          // free running ticks: between n-1 and n periods
          next_st.wait_cnt = st.wait_cnt - 3'h1;
      end
      SPS_SLEEP:
      begin
        if (wake_hit)
        begin
          next_st.fsm                 = SPS_RUN;
          next_st.sleep.sleep_request = 1'b0;
        end
      end
      default:
      begin
        next_st.fsm = SPS_RUN;
      end
    endcase

    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `SPS_RESP_OKAY;
      case (s_axi_araddr)
        `SPS_ADDR_CTRL:  next_st.rdata = 32'(st.ctrl);
        `SPS_ADDR_SLEEP: next_st.rdata = 32'(st.sleep);
        `SPS_ADDR_STAT:  next_st.rdata = 32'({sync2[2], st.stat});
        `SPS_ADDR_CLR:   next_st.rdata = 32'h0;
        `SPS_ADDR_IEN:   next_st.rdata = 32'(st.ien);
        default:
        begin
          next_st.rdata = 32'h0;
          next_st.rresp = `SPS_RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    next_st.arready = ~next_st.rvalid;

    // Pin and reset follow the next state so they move with it
    case (next_st.ctrl.src)
      `SPS_SRC_STATIC:
      begin
        next_st.pin_o  = next_st.ctrl.static_output_bit;
        next_st.pin_oe = 1'b1;
      end
      `SPS_SRC_SLEEP:
      begin
        // open drain switch floats only in sleep
        if (next_st.ctrl.low_resistance_switch_enable)
        begin
          next_st.pin_o  = 1'b0;
          next_st.pin_oe = (next_st.fsm != SPS_SLEEP);
        end
        else
        begin
          next_st.pin_o  = (next_st.fsm == SPS_SLEEP);
          next_st.pin_oe = 1'b1;
        end
      end
      default:
      begin
        // Other sources show the interrupt, active low
        next_st.pin_o  = ~(|(next_st.stat & next_st.ien));
        next_st.pin_oe = 1'b1;
      end
    endcase
    // push-pull reset low in sleep when enabled
    next_st.rst_n = ~((next_st.fsm == SPS_SLEEP) & next_st.sleep.sleep_reset_enable);
    next_st.irq   = |(next_st.stat & next_st.ien);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st          <= '0;
      st.fsm      <= SPS_RUN;
      st.ctrl     <= sps_ctrl_t'(`SPS_CTRL_RST);
      st.sleep    <= sps_sleep_t'(`SPS_SLEEP_RST);
      st.pin_oe   <= 1'b1;
      st.rst_n    <= 1'b1;
      st.awready  <= 1'b1;
      st.wready   <= 1'b1;
      st.arready  <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Outputs straight from the state register
  assign s_axi_awready       = st.awready;
  assign s_axi_wready        = st.wready;
  assign s_axi_bvalid        = st.bvalid;
  assign s_axi_bresp         = st.bresp;
  assign s_axi_arready       = st.arready;
  assign s_axi_rvalid        = st.rvalid;
  assign s_axi_rresp         = st.rresp;
  assign s_axi_rdata         = st.rdata;
  assign power_switch_pin_o  = st.pin_o;
  assign power_switch_pin_oe = st.pin_oe;
  assign host_reset_out_n    = st.rst_n;
  assign irq                 = st.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_pin;
    !$past(aresetn) |-> st.ctrl.src == `SPS_SRC_STATIC && power_switch_pin_oe && !power_switch_pin_o;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("pin not on after reset");

  property p_awake_low;
    (sleep_cfg && st.fsm != SPS_SLEEP) |-> power_switch_pin_oe && !power_switch_pin_o;
  endproperty
  a_awake_low: assert property (p_awake_low) else $error("switch off while awake");

  property p_sleep_float;
    (sleep_cfg && st.fsm == SPS_SLEEP) |-> !power_switch_pin_oe;
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("switch on in sleep");

  property p_sleep_rst;
    (st.fsm == SPS_SLEEP) |-> host_reset_out_n == !st.sleep.sleep_reset_enable;
  endproperty
  a_sleep_rst: assert property (p_sleep_rst) else $error("host reset wrong in sleep");

  property p_wake;
    (st.fsm == SPS_SLEEP && wake_hit) |=> st.fsm == SPS_RUN && host_reset_out_n && st.stat.wake
      && (!sleep_cfg || power_switch_pin_oe);
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restore host");

  property p_evt_only;
    (st.fsm == SPS_RUN && set_evt.alarm) |=> st.stat.alarm && host_reset_out_n;
  endproperty
  a_evt_only: assert property (p_evt_only) else $error("alarm event lost");

  property p_timeout;
    (st.fsm == SPS_SWAIT && st.sleep.sleep_request && !wake_hit) |=>
      (st.fsm == SPS_SLEEP) == ($past(st.wait_cnt) == 3'h0);
  endproperty
  a_timeout: assert property (p_timeout) else $error("sleep entry at wrong count");

  property p_abort;
    (st.fsm == SPS_SWAIT && wake_hit) |=> st.fsm == SPS_RUN && !st.sleep.sleep_request;
  endproperty
  a_abort: assert property (p_abort) else $error("trigger did not abort wait");

  property p_refuse;
    (wr_go && st.wlane && st.awaddr == `SPS_ADDR_SLEEP && !st.sleep.sleep_request && !req_ok)
      |=> !st.sleep.sleep_request;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unsafe sleep request taken");

  property p_sleep_flag;
    $rose(st.fsm == SPS_SLEEP) |-> st.sleep.sleep_occurred_flag;
  endproperty
  a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag not set");

  c_sleep:  cover property ($rose(st.fsm == SPS_SLEEP));
  c_wake:   cover property (st.fsm == SPS_SLEEP ##1 st.fsm == SPS_RUN);
  c_abort:  cover property (st.fsm == SPS_SWAIT && wake_hit);
  c_refuse: cover property (wr_go && st.awaddr == `SPS_ADDR_SLEEP && wr_sleep.sleep_request
                            && !req_ok);

endmodule

// ===== sps_host_model.sv
// Host microcontroller model on the far side of the power switch and reset pins
`timescale 1ns/1ps
module sps_host_model
(
  input  wire logic aclk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic host_reset_out_n,
  output logic      pin_level,
  output logic      host_powered,
  output logic      host_in_reset
);
  // ************************************
  // Pad level and host supply
  // ************************************
  // Released pad floats up through the host load, so the ground path opens
  assign pin_level    = pin_oe ? pin_o : 1'b1;
  // Host ground is switched: powered only while the pad is pulled low
  assign host_powered = (pin_level === 1'b0);
  // ************************************
  // Host reset input
  // ************************************
  // push-pull reset input
  // No internal pull-up: the reset level is exactly what the block drives
  always_ff @(posedge aclk)
  begin
    host_in_reset <= (host_reset_out_n !== 1'b1);
  end
endmodule

// ===== sps_power_ctrl_tb.sv
// Self-checking testbench of the sleep power control block
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_power_ctrl_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, alarm_evt, timer_evt;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic pin_i, pin_o, pin_oe, rst_n, powered, in_rst;
  int fails = 0;
  int cmp_count = 0;
  int n;
  // Short tick keeps the sleep timeout within a short run
  localparam int TICK = 8;
  sps_power_ctrl #(.TICK_CYCLES(TICK)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .alarm_evt(alarm_evt), .timer_evt(timer_evt), .power_switch_pin_i(pin_i),
    .power_switch_pin_o(pin_o), .power_switch_pin_oe(pin_oe),
    .host_reset_out_n(rst_n), .irq(irq));
  sps_host_model host (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
    .host_reset_out_n(rst_n), .pin_level(pin_i), .host_powered(powered),
    .host_in_reset(in_rst));
  // ************************************
  // Shared checking and bus tasks
  // ************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Both channels offered together, each released at its own handshake edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; wvalid <= 1'b1;
    bready <= 1'b1;
    // Each channel drops at its own handshake edge; done once both are taken
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if ((awready === 1'b1 || awvalid !== 1'b1) && (wready === 1'b1 || wvalid !== 1'b1)) break;
    end
    // Reading just after the edge sees the values sampled at it
    for (k = 0; k < 100 && bvalid !== 1'b1; k++) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int k;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (arready === 1'b1) break;
    end
    for (k = 0; k < 100 && rvalid !== 1'b1; k++) @(posedge aclk);
    v = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  // ************************************
  // Scenarios
  // ************************************
  task automatic t_reset;
    chk("pin drive", {pin_oe, pin_o}, 2'b10);
    chk("host reset", rst_n, 1'b1);
    axi_rd(`SPS_ADDR_CTRL, d, `SPS_RESP_OKAY);
    chk("ctrl", d, 32'h07);
    axi_rd(8'h14, d, `SPS_RESP_SLVERR);
    chk("unmapped", d, 32'h0);
    axi_wr(8'h14, 32'h1, `SPS_RESP_SLVERR);
  endtask
  task automatic t_refuse;
    axi_wr(`SPS_ADDR_SLEEP, 32'h80, `SPS_RESP_OKAY);
    axi_rd(`SPS_ADDR_SLEEP, d, `SPS_RESP_OKAY);
    chk("req no enable", d[7], 1'b0);
    axi_wr(`SPS_ADDR_IEN, 32'h1, `SPS_RESP_OKAY);
    axi_wr(`SPS_ADDR_CTRL, 32'h27, `SPS_RESP_OKAY);
    axi_wr(`SPS_ADDR_SLEEP, 32'h80, `SPS_RESP_OKAY);
    axi_rd(`SPS_ADDR_SLEEP, d, `SPS_RESP_OKAY);
    chk("req halted", d[7], 1'b0);
    axi_wr(`SPS_ADDR_CTRL, 32'h07, `SPS_RESP_OKAY);
  endtask
  task automatic t_irq_only;
    axi_wr(`SPS_ADDR_IEN, 32'h3, `SPS_RESP_OKAY);
    timer_evt <= 1'b1;
    for (n = 0; n < 20 && irq !== 1'b1; n++) @(posedge aclk);
    chk("irq on timer", irq, 1'b1);
    chk("pins kept", {pin_oe, pin_o, rst_n}, 3'b101);
    axi_wr(`SPS_ADDR_SLEEP, 32'h80, `SPS_RESP_OKAY);
    axi_rd(`SPS_ADDR_SLEEP, d, `SPS_RESP_OKAY);
    chk("req pending", d[7], 1'b0);
    axi_wr(`SPS_ADDR_IEN, 32'h1, `SPS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq masked", irq, 1'b0);
    axi_wr(`SPS_ADDR_CLR, 32'h7, `SPS_RESP_OKAY);
    timer_evt <= 1'b0;
    axi_rd(`SPS_ADDR_STAT, d, `SPS_RESP_OKAY);
    chk("stat cleared", d[2:0], 3'b000);
  endtask
  task automatic t_sleep;
    // source moved only from 111 to 110
    axi_wr(`SPS_ADDR_CTRL, 32'h16, `SPS_RESP_OKAY);
    axi_wr(`SPS_ADDR_SLEEP, 32'hc3, `SPS_RESP_OKAY);
    chk("pin low awake", {pin_oe, pin_o}, 2'b10);
    for (n = 0; n < 60 && pin_oe !== 1'b0; n++) @(posedge aclk);
    // Free-running tick gives two to three periods plus bus latency
    chk("sleep delay", (n >= 2 * TICK - 2) && (n <= 3 * TICK + 4), 1'b1);
    chk("host unpowered", powered, 1'b0);
    chk("reset asserted", rst_n, 1'b0);
    repeat (4) @(posedge aclk);
    chk("host held in reset", in_rst, 1'b1);
    alarm_evt <= 1'b1;
    for (n = 0; n < 20 && rst_n !== 1'b1; n++) @(posedge aclk);
    chk("power before release", powered, 1'b1);
    chk("reset released", rst_n, 1'b1);
    axi_rd(`SPS_ADDR_STAT, d, `SPS_RESP_OKAY);
    chk("wake cause", d[2:0], 3'b101);
    chk("wake irq", irq, 1'b1);
    axi_rd(`SPS_ADDR_SLEEP, d, `SPS_RESP_OKAY);
    chk("sleep flag", d[7:0], 32'h4b);
    axi_wr(`SPS_ADDR_CLR, 32'h7, `SPS_RESP_OKAY);
    axi_wr(`SPS_ADDR_SLEEP, 32'h0, `SPS_RESP_OKAY);
    alarm_evt <= 1'b0;
  endtask
  task automatic t_abort;
    axi_wr(`SPS_ADDR_SLEEP, 32'hc7, `SPS_RESP_OKAY);
    repeat (10) @(posedge aclk);
    alarm_evt <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(`SPS_ADDR_SLEEP, d, `SPS_RESP_OKAY);
    chk("req cleared", d[7], 1'b0);
    repeat (7 * TICK) @(posedge aclk);
    chk("still awake", {pin_oe, pin_o, rst_n}, 3'b101);
    axi_wr(`SPS_ADDR_CLR, 32'h7, `SPS_RESP_OKAY);
    alarm_evt <= 1'b0;
  endtask
  // ************************************
  // Verdict, clock, watchdog and sequence
  // ************************************
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Whole sequence needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    tally_and_finish;
  end
  initial
  begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; alarm_evt = 1'b0; timer_evt = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_refuse;
    t_irq_only;
    t_sleep;
    t_abort;
    tally_and_finish;
  end
endmodule
